// file: shared/wdr_consts.svh
// Purpose: Constants for the watchdog and reset-flag block
// Assumes: 8-bit register port, 40 MHz mclk
// Notes:   Offsets are register indices on the plain register port
`ifndef WDR_CONSTS_SVH
`define WDR_CONSTS_SVH

`define WDR_OFF_CTRL       4'h0
`define WDR_OFF_FLAGS      4'h1
`define WDR_OFF_STATUS     4'h2
`define WDR_OFF_IRQ_STAT   4'h3
`define WDR_OFF_IRQ_MASK   4'h4

`define WDR_CTRL_RESET     8'h53
`define WDR_KEY_A          5'h0A
`define WDR_KEY_B          5'h15
`define WDR_KEY_MSB        7
`define WDR_KEY_LSB        3
`define WDR_PER_MSB        2
`define WDR_PER_LSB        0

`define WDR_FLAG_SOFT_BIT  0
`define WDR_FLAG_LV_BIT    2

`define WDR_IRQ_TIMEOUT    0
`define WDR_IRQ_SOFT       1
`define WDR_IRQ_LV         2

`define WDR_CLK_HZ         40000000
`define WDR_LSC_HZ         32000
`define WDR_LSC_DIV        (`WDR_CLK_HZ / `WDR_LSC_HZ)
`define WDR_SRESET_US      1000
`define WDR_SRESET_CYC     ((`WDR_SRESET_US * (`WDR_CLK_HZ / 1000000)))
`define WDR_LVQ_US         120
`define WDR_LVQ_CYC        ((`WDR_LVQ_US * (`WDR_CLK_HZ / 1000000)))
`define WDR_RST_PULSE_CYC  4

`endif

// file: shared/wdr_pkg.sv
// Purpose: Types for the watchdog and reset-flag block
// Assumes: Constants come from wdr_consts.svh
// Notes:   Register bus carried as packed structs
package wdr_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } wdr_bus_req_t;

  typedef struct packed {
    logic clear_watchdog_instruction;
    logic halt;
    logic low_power;
  } wdr_core_t;

  typedef enum logic [1:0] {
    WDR_RUN,
    WDR_SOFT_WAIT,
    WDR_RESET_OUT
  } wdr_state_t;

endpackage : wdr_pkg

// file: rtl/wdr_watchdog.sv
// Purpose: Watchdog timer with keyed control and reset-cause flags
// Assumes: Core strobes on mclk; low_supply_n is an asynchronous pin
// Notes:   Low-speed clock is an enable pulse divided from mclk
`timescale 1ns/1ps
`include "wdr_consts.svh"

// How it works
// - Watchdog counts only low-speed oscillator ticks, about 32 kHz.
// - Period field selects 2^8,10,12,14,15,16,17,18 low-speed cycles.
// - Watchdog enabled only while key field holds 01010 or 10101.
// - Any other key value resets device after fixed soft-reset delay.
// - Control register powers up with key 01010, period 011.
// - Key reset sets flag bit 0; only software zero write clears.
// - Qualified low-voltage reset sets flag bit 2; software clears only.
// - Flag register bits 7..3 and 1 read zero.
// - Normal-mode overflow causes full reset and sets timeout flag.
// - Low-power overflow sets timeout and power-down, resets only PC and SP.
// - Counter cleared by key reset, clear instruction, or halt.
// - Low-voltage reset active in fast/slow, disabled in sleep/idle.
// - Low supply acts only after persisting past qualification time.
// - Power-on reset sets program counter to zero.
// - Halt sets power-down, clears timeout; clear instruction clears power-down.
// - Power-on clears both flags; low-voltage reset leaves them unchanged.
module wdr_watchdog #(
  parameter int unsigned SRESET_CYC = `WDR_SRESET_CYC,
  parameter int unsigned LVQ_CYC    = `WDR_LVQ_CYC,
  parameter int unsigned LSC_DIV    = `WDR_LSC_DIV
) (
  // Clock and power-on reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // Register port
  input  wire wdr_pkg::wdr_bus_req_t bus_req,
  output logic [7:0]                rdata,
  // Core events
  input  wire wdr_pkg::wdr_core_t   core,
  // Supply monitor pin
  input  wire logic                 low_supply_n,
  // Reset, status flag and interrupt outputs
  output logic                      sys_reset,
  output logic                      pc_sp_reset,
  output logic                      timeout_status_flag,
  output logic                      power_down_flag,
  output logic                      irq
);
  import wdr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [4:0] period_log2(input logic [2:0] sel);
    case (sel)
      3'h0:    period_log2 = 5'h08;
      3'h1:    period_log2 = 5'h0A;
      3'h2:    period_log2 = 5'h0C;
      3'h3:    period_log2 = 5'h0E;
      3'h4:    period_log2 = 5'h0F;
      3'h5:    period_log2 = 5'h10;
      3'h6:    period_log2 = 5'h11;
      default: period_log2 = 5'h12;
    endcase
  endfunction : period_log2

  function automatic logic key_ok(input logic [4:0] key);
    key_ok = (key == `WDR_KEY_A) || (key == `WDR_KEY_B);
  endfunction : key_ok

  ////////////////////////////////////////////////////////////////////////////
  // Registers and signals

  logic [7:0]  ctrl_q;
  logic        soft_flag_q;
  logic        lv_flag_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic [15:0] div_q;
  logic        tick_q;
  logic [18:0] wdt_cnt_q;
  logic [31:0] sreset_cnt_q;
  logic [31:0] lvq_cnt_q;
  logic [2:0]  pulse_cnt_q;
  logic        ls_meta_q;
  logic        ls_sync_q;
  wdr_state_t  state_q;
  logic        full_pulse_q;

  logic        wr_ctrl;
  logic        wr_flags;
  logic        key_valid;
  logic        overflow;
  logic        soft_fire;
  logic        lv_fire;
  logic        full_reset;
  logic        wd_norm_fire;
  logic        wd_lp_fire;
  logic [2:0]  events;

  assign wr_ctrl   = bus_req.wr && (bus_req.addr == `WDR_OFF_CTRL);
  assign wr_flags  = bus_req.wr && (bus_req.addr == `WDR_OFF_FLAGS);
  assign key_valid = key_ok(ctrl_q[`WDR_KEY_MSB:`WDR_KEY_LSB]);
  // Single-bit test: bit n of the 19-bit count set means 2^n reached
  assign overflow  = key_valid && (wdt_cnt_q[period_log2(ctrl_q[2:0])] == 1'b1);
  assign soft_fire = (state_q == WDR_SOFT_WAIT) && (sreset_cnt_q >= SRESET_CYC - 1);
  // Low-supply detect masked in sleep/idle
  assign lv_fire   = !core.low_power && (lvq_cnt_q >= LVQ_CYC);
  assign wd_norm_fire = overflow && !core.low_power;
  assign wd_lp_fire   = overflow && core.low_power;
  assign full_reset   = soft_fire || lv_fire || wd_norm_fire;
  assign events = {lv_fire, soft_fire, overflow};

  ////////////////////////////////////////////////////////////////////////////
  // Low-speed tick: enable pulse at about 32 kHz

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 16'(LSC_DIV - 1)) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wdt_cnt_q <= 19'h00000;
    end else if (full_reset || overflow || core.clear_watchdog_instruction || core.halt
                 || state_q != WDR_RUN) begin
      wdt_cnt_q <= 19'h00000;
    end else if (tick_q && key_valid) begin
      wdt_cnt_q <= wdt_cnt_q + 19'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; reloads on any full reset

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `WDR_CTRL_RESET;
    end else if (full_reset) begin
      ctrl_q <= `WDR_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= bus_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key-fault sequencer and reset pulse

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q      <= WDR_RUN;
      sreset_cnt_q <= 32'h00000000;
      pulse_cnt_q  <= 3'h0;
      full_pulse_q <= 1'b0;
    end else begin
      case (state_q)
        WDR_RUN: begin
          sreset_cnt_q <= 32'h00000000;
          if (lv_fire || wd_norm_fire) begin
            state_q     <= WDR_RESET_OUT;
            pulse_cnt_q <= 3'h0;
          end else if (!key_valid) begin
            state_q <= WDR_SOFT_WAIT;
          end
        end
        WDR_SOFT_WAIT: begin
          sreset_cnt_q <= sreset_cnt_q + 32'h00000001;
          if (full_reset) begin
            state_q     <= WDR_RESET_OUT;
            pulse_cnt_q <= 3'h0;
          end
        end
        WDR_RESET_OUT: begin
          pulse_cnt_q <= pulse_cnt_q + 3'h1;
          if (pulse_cnt_q == 3'(`WDR_RST_PULSE_CYC - 1)) begin
            state_q <= WDR_RUN;
          end
        end
        default: state_q <= WDR_RUN;
      endcase
      full_pulse_q <= full_reset;
    end
  end

  // Reset held for a fixed width so downstream logic sees it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sys_reset   <= 1'b1;
      pc_sp_reset <= 1'b1;
    end else begin
      sys_reset   <= full_reset || (state_q == WDR_RESET_OUT);
      pc_sp_reset <= full_reset || (state_q == WDR_RESET_OUT) || wd_lp_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-supply synchroniser and qualification

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ls_meta_q <= 1'b0;
      ls_sync_q <= 1'b0;
    end else begin
      ls_meta_q <= !low_supply_n;
      ls_sync_q <= ls_meta_q;
    end
  end

  // Short dips restart the count and never fire
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lvq_cnt_q <= 32'h00000000;
    end else if (!ls_sync_q || core.low_power || lv_fire) begin
      lvq_cnt_q <= 32'h00000000;
    end else begin
      lvq_cnt_q <= lvq_cnt_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset-cause flags: hardware set wins over software clear

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      soft_flag_q <= 1'b0;
      lv_flag_q   <= 1'b0;
    end else begin
      if (soft_fire) begin
        soft_flag_q <= 1'b1;
      end else if (wr_flags && !bus_req.wdata[`WDR_FLAG_SOFT_BIT]) begin
        soft_flag_q <= 1'b0;
      end
      if (lv_fire) begin
        lv_flag_q <= 1'b1;
      end else if (wr_flags && !bus_req.wdata[`WDR_FLAG_LV_BIT]) begin
        lv_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout and power-down status

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      timeout_status_flag <= 1'b0;
      power_down_flag     <= 1'b0;
    end else if (overflow) begin
      timeout_status_flag <= 1'b1;
      if (core.low_power) begin
        power_down_flag <= 1'b1;
      end
    end else if (core.halt) begin
      timeout_status_flag <= 1'b0;
      power_down_flag     <= 1'b1;
    end else if (core.clear_watchdog_instruction) begin
      power_down_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end else begin
      if (bus_req.wr && bus_req.addr == `WDR_OFF_IRQ_MASK) begin
        irq_mask_q <= bus_req.wdata[2:0];
      end
      if (bus_req.wr && bus_req.addr == `WDR_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~bus_req.wdata[2:0]) | events;
      end else begin
        irq_stat_q <= irq_stat_q | events;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `WDR_OFF_CTRL:     rdata <= ctrl_q;
        `WDR_OFF_FLAGS:    rdata <= {5'h00, lv_flag_q, 1'b0, soft_flag_q};
        `WDR_OFF_STATUS:   rdata <= {4'h0, key_valid, state_q != WDR_RUN,
                                     power_down_flag, timeout_status_flag};
        `WDR_OFF_IRQ_STAT: rdata <= {5'h00, irq_stat_q};
        `WDR_OFF_IRQ_MASK: rdata <= {5'h00, irq_mask_q};
        default:           rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : wdr_watchdog

// file: verif/wdr_watchdog_asserts.sv
// Purpose: Port-level checks for the watchdog block
// Assumes: Single mclk domain, reset async high
// Notes:   Bound onto every wdr_watchdog instance
`timescale 1ns/1ps
`include "wdr_consts.svh"
module wdr_watchdog_chk
  import wdr_pkg::*;
#(
  parameter int unsigned SRESET_CYC = 8,
  parameter int unsigned LVQ_CYC    = 8,
  parameter int unsigned LSC_DIV    = 4
) (
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 reset,
  // Watched ports
  input wire wdr_pkg::wdr_bus_req_t bus_req,
  input wire logic [7:0]           rdata,
  input wire wdr_pkg::wdr_core_t   core,
  input wire logic                 low_supply_n,
  input wire logic                 sys_reset,
  input wire logic                 pc_sp_reset,
  input wire logic                 timeout_status_flag,
  input wire logic                 power_down_flag,
  input wire logic                 irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("rdata not zero outside read reply");
  a_flags_unused: assert property ($past(bus_req.rd) && $past(bus_req.addr) == `WDR_OFF_FLAGS
    |-> rdata[7:3] == 5'h00 && !rdata[1])
    else $error("unused flag bits read nonzero");
  a_pcsp_with_sys: assert property (sys_reset |-> pc_sp_reset)
    else $error("full reset without pc/sp reset");
  a_halt_flags: assert property (core.halt && !pc_sp_reset |=> power_down_flag
    && !timeout_status_flag)
    else $error("halt did not set power-down and clear timeout");
  a_clr_pdf: assert property (core.clear_watchdog_instruction && !core.halt && !core.low_power && !pc_sp_reset
    |=> !power_down_flag)
    else $error("clear instruction left power-down set");
  a_lp_timeout: assert property ($rose(pc_sp_reset) && !sys_reset
    |-> ##[0:1] (timeout_status_flag && power_down_flag))
    else $error("low-power overflow flags wrong");
  a_burst_len: assert property ($rose(sys_reset) |-> sys_reset[*4])
    else $error("full reset burst too short");
  a_pdf_cause: assert property ($changed(power_down_flag) |-> $past(core.halt)
    || $past(core.clear_watchdog_instruction) || pc_sp_reset || $past(pc_sp_reset))
    else $error("power-down flag changed without cause");
  a_to_cause: assert property ($rose(timeout_status_flag)
    |-> pc_sp_reset || $past(pc_sp_reset))
    else $error("timeout flag rose without overflow");
  c_full: cover property ($rose(sys_reset));
  c_lp: cover property (pc_sp_reset && !sys_reset);
  c_irq: cover property ($rose(irq));
endmodule : wdr_watchdog_chk

bind wdr_watchdog wdr_watchdog_chk #(
  .SRESET_CYC(SRESET_CYC), .LVQ_CYC(LVQ_CYC), .LSC_DIV(LSC_DIV)
) u_chk (
  .mclk(mclk), .reset(reset), .bus_req(bus_req), .rdata(rdata), .core(core),
  .low_supply_n(low_supply_n), .sys_reset(sys_reset), .pc_sp_reset(pc_sp_reset),
  .timeout_status_flag(timeout_status_flag), .power_down_flag(power_down_flag), .irq(irq)
);

// file: verif/wdr_watchdog_bench.sv
// Purpose: Self-checking bench for the watchdog block
// Assumes: Short counts: LSC_DIV 4, delays 8
// Notes:   Internal resets reload control, so period is rewritten after each
`timescale 1ns/1ps
`include "wdr_consts.svh"
module wdr_watchdog_bench;
  import wdr_pkg::*;
  logic         mclk, reset, low_supply_n, sys_reset, pc_sp_reset, to_f, pd_f, irq;
  wdr_bus_req_t req;
  wdr_core_t    core;
  logic [7:0]   rdata, rv;
  int           n_fail, n_tests, cyc, n;

  wdr_watchdog #(.SRESET_CYC(8), .LVQ_CYC(8), .LSC_DIV(4)) u_wdr_watchdog (
    .mclk(mclk), .reset(reset), .bus_req(req), .rdata(rdata), .core(core),
    .low_supply_n(low_supply_n), .sys_reset(sys_reset), .pc_sp_reset(pc_sp_reset),
    .timeout_status_flag(to_f), .power_down_flag(pd_f), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic summarize;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask : wr
  // Reply is sampled just after the edge that takes the read
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
    #1 d = rdata;
  endtask : rd
  task automatic pulse(input logic c, input logic h);
    @(posedge mclk);
    core.clear_watchdog_instruction <= c;
    core.halt    <= h;
    @(posedge mclk);
    core.clear_watchdog_instruction <= 1'b0;
    core.halt    <= 1'b0;
  endtask : pulse
  task automatic wait_rst(input int lim);
    n = 0;
    @(negedge mclk);
    while (!pc_sp_reset && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_rst
  task automatic settle;
    while (pc_sp_reset) @(negedge mclk);
    repeat (2) @(posedge mclk);
  endtask : settle
  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc > 30000) begin
        n_fail++;
        summarize();
      end
    end
  end
  initial begin
    req = '0;
    core = '0;
    low_supply_n = 1'b1;
    reset = 1'b1;
    n_fail = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(`WDR_OFF_CTRL, rv); chk("ctrl", 8'h53, rv);
    rd(`WDR_OFF_FLAGS, rv); chk("flags", 8'h00, rv);
    wr(4'hF, 8'hFF);
    rd(4'hF, rv); chk("unmapped", 8'h00, rv);
    wr(`WDR_OFF_CTRL, 8'hA8);
    repeat (3) begin
      pulse(1'b1, 1'b0);
      wait_rst(900); chk("alive", 8'h00, {7'h0, pc_sp_reset});
    end
    pulse(1'b1, 1'b0);
    wait_rst(1100); chk("ovf_time", 8'h01, {7'h0, n >= 1010 && n <= 1040});
    chk("ovf_full", 8'h01, {7'h0, sys_reset});
    settle();
    chk("to_set", 8'h01, {7'h0, to_f});
    chk("irq_masked", 8'h00, {7'h0, irq});
    rd(`WDR_OFF_CTRL, rv); chk("ctrl_reload", 8'h53, rv);
    pulse(1'b0, 1'b1);
    #1 chk("halt", 8'h02, {6'h0, pd_f, to_f});
    core.low_power <= 1'b1;
    wr(`WDR_OFF_CTRL, 8'h50);
    pulse(1'b0, 1'b1);
    wait_rst(1100); chk("lp_sys", 8'h00, {7'h0, sys_reset});
    @(negedge mclk) chk("lp_flags", 8'h03, {6'h0, pd_f, to_f});
    low_supply_n <= 1'b0;
    wait_rst(40); chk("lv_sleep", 8'h00, {7'h0, pc_sp_reset});
    low_supply_n <= 1'b1;
    core.low_power <= 1'b0;
    pulse(1'b1, 1'b0);
    #1 chk("clr_pd", 8'h00, {7'h0, pd_f});
    @(posedge mclk) low_supply_n <= 1'b0;
    repeat (5) @(posedge mclk);
    low_supply_n <= 1'b1;
    wait_rst(30); chk("lv_short", 8'h00, {7'h0, pc_sp_reset});
    low_supply_n <= 1'b0;
    wait_rst(40); chk("lv_fire", 8'h01, {7'h0, sys_reset});
    low_supply_n <= 1'b1;
    settle();
    chk("lv_keep", 8'h01, {6'h0, pd_f, to_f});
    rd(`WDR_OFF_FLAGS, rv); chk("lv_flag", 8'h04, rv);
    // Status: key valid after reload, run state, timeout kept, power-down clear
    rd(`WDR_OFF_STATUS, rv); chk("status", 8'h09, rv);
    wr(`WDR_OFF_IRQ_MASK, 8'h02);
    rd(`WDR_OFF_IRQ_MASK, rv); chk("mask", 8'h02, rv);
    wr(`WDR_OFF_CTRL, 8'h00);
    wait_rst(60); chk("soft_time", 8'h01, {7'h0, n >= 6 && n <= 20});
    settle();
    rd(`WDR_OFF_FLAGS, rv); chk("soft_flag", 8'h05, rv);
    chk("irq_on", 8'h01, {7'h0, irq});
    wr(`WDR_OFF_IRQ_STAT, 8'h07);
    wr(`WDR_OFF_FLAGS, 8'hFA);
    rd(`WDR_OFF_FLAGS, rv); chk("flag_clr", 8'h00, rv);
    chk("irq_off", 8'h00, {7'h0, irq});
    summarize();
  end
endmodule : wdr_watchdog_bench
